// file: hdl/wdog_reset_flags.v
/*
 * Watchdog timer with prescaler, refresh sequence, start control and
 * underflow action, plus the reset-cause flag register, behind a classic
 * Wishbone slave with 32-bit data.
 * Assumes resetn is the power-on / voltage-monitor reset, that option pins
 * are static non-volatile values, that the oscillator pin is much slower
 * than clk, and that the surrounding chip turns wdog_reset into a reset.
 */
// Added by the designer: register access over Wishbone.
`include "wdog_defs.vh"

module wdog_reset_flags #(
    parameter COUNT_W    = 16,
    parameter COUNT_VAL0 = `COUNT_SEL0,
    parameter COUNT_VAL1 = `COUNT_SEL1,
    parameter COUNT_VAL2 = `COUNT_SEL2,
    parameter COUNT_VAL3 = `COUNT_SEL3
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        auto_start_option,
    input  wire [1:0]  count_value_select,
    input  wire        loco_clk_pin,
    input  wire        pin_reset,
    input  wire        program_reset,
    input  wire        cpu_wait,
    input  wire        cpu_stop,
    output reg         wdog_reset,
    output wire        irq
);

    // bus decode
    wire [7:0]  idx;
    wire        req;
    wire        wr;
    wire [7:0]  wbyte;

    // synchronisers for pin-side inputs
    reg         loco_s1;
    reg         loco_s2;
    reg         loco_s3;
    reg         pinrst_s1;
    reg         pinrst_s2;
    reg         auto_s1;
    reg         auto_s2;
    reg  [1:0]  cvs_s1;
    reg  [1:0]  cvs_s2;

    // option capture
    reg  [1:0]  opt_wait;
    reg         opt_valid;
    reg         opt_auto_stop;
    reg  [1:0]  opt_count_sel;

    // software registers
    reg         action_sel;
    reg  [1:0]  prescale_sel;
    reg  [7:0]  protect_mode;
    reg  [7:0]  periodic_ctrl;
    reg         irq_status;
    reg         irq_enable;
    reg         cold_flag;
    reg         pin_flag;
    reg         prog_flag;
    reg         dog_flag;

    // watchdog core
    reg         started;
    reg         refresh_armed;
    reg  [6:0]  prescaler;
    reg  [3:0]  loco_div;
    reg  [COUNT_W-1:0] counter;
    reg  [COUNT_W-1:0] load_val;
    reg  [6:0]  div_mask;
    wire        sys_reset;
    wire        reinit;
    wire        loco_rise;
    wire        loco_src;
    wire        running;
    wire        cnt_en;
    wire        tick_cpu;
    wire        tick_loco;
    wire        tick;
    wire        underflow;
    wire        refresh_fire;
    wire        start_wr;
    wire        clear_underflow;

    assign idx   = wb_adr_i[9:2];
    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // only the low byte lane holds register data
    assign wr    = req & wb_we_i & wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    // any of the three warm resets restarts the watchdog
    assign sys_reset = pinrst_s2 | program_reset | wdog_reset;
    assign reinit    = ~resetn | sys_reset;

    // two flops on every pin before use; third flop only for edge detect
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            loco_s1   <= 1'b0;
            loco_s2   <= 1'b0;
            loco_s3   <= 1'b0;
            pinrst_s1 <= 1'b0;
            pinrst_s2 <= 1'b0;
            auto_s1   <= 1'b0;
            auto_s2   <= 1'b0;
            cvs_s1    <= 2'b00;
            cvs_s2    <= 2'b00;
        end
        else
        begin
            loco_s1   <= loco_clk_pin;
            loco_s2   <= loco_s1;
            loco_s3   <= loco_s2;
            pinrst_s1 <= pin_reset;
            pinrst_s2 <= pinrst_s1;
            auto_s1   <= auto_start_option;
            auto_s2   <= auto_s1;
            cvs_s1    <= count_value_select;
            cvs_s2    <= cvs_s1;
        end
    end

    assign loco_rise = loco_s2 & ~loco_s3;

    // options are caught once the synchronisers have settled after reset
    always @(posedge clk)
    begin
        if (reinit)
        begin
            opt_wait      <= 2'd0;
            opt_valid     <= 1'b0;
            opt_auto_stop <= 1'b1;
            opt_count_sel <= 2'b11;
        end
        else if (!opt_valid)
        begin
            if (opt_wait == `OPT_SETTLE)
            begin
                opt_valid     <= 1'b1;
                opt_auto_stop <= auto_s2;
                opt_count_sel <= cvs_s2;
            end
            else
            begin
                opt_wait <= opt_wait + 2'd1;
            end
        end
    end

    // reload value from the option select
    always @*
    begin
        case (opt_count_sel)
            2'b00:   load_val = COUNT_VAL0[COUNT_W-1:0];
            2'b01:   load_val = COUNT_VAL1[COUNT_W-1:0];
            2'b10:   load_val = COUNT_VAL2[COUNT_W-1:0];
            default: load_val = COUNT_VAL3[COUNT_W-1:0];
        endcase
    end

    // prescaler mask; mask compare on a free counter gives 2, 16 or 128
    always @*
    begin
        case (prescale_sel)
            `PS_DIV2:   div_mask = `MASK_DIV2;
            `PS_DIV16:  div_mask = `MASK_DIV16;
            `PS_DIV128: div_mask = `MASK_DIV128;
            default:    div_mask = `MASK_DIV16;
        endcase
    end

    assign loco_src = (prescale_sel == `PS_LOCO);
    assign running  = opt_valid & (started | ~opt_auto_stop);
    // the low-speed oscillator keeps running through wait and stop
    assign cnt_en   = running & ~(~loco_src & (cpu_wait | cpu_stop));

    assign tick_cpu  = cnt_en & ~loco_src & ((prescaler & div_mask) == div_mask);
    assign tick_loco = cnt_en & loco_src & loco_rise & (loco_div == `LOCO_DIV_MASK);
    assign tick      = tick_cpu | tick_loco;

    assign underflow    = tick & (counter == {{(COUNT_W-1){1'b0}}, 1'b1});
    assign refresh_fire = wr & (idx == `IDX_REFRESH) & refresh_armed &
                          (wbyte == `REFRESH_FIRE);
    assign start_wr     = wr & (idx == `IDX_START);

    // prescalers: never touched by refresh, so the first period may be short
    always @(posedge clk)
    begin
        if (reinit)
        begin
            prescaler <= 7'h00;
            loco_div  <= 4'h0;
        end
        else
        begin
            if (cnt_en & ~loco_src)
            begin
                prescaler <= prescaler + 7'h01;
            end
            if (cnt_en & loco_src & loco_rise)
            begin
                loco_div <= loco_div + 4'h1;
            end
        end
    end

    // start latch and refresh sequence tracking
    always @(posedge clk)
    begin
        if (reinit)
        begin
            started       <= 1'b0;
            refresh_armed <= 1'b0;
        end
        else
        begin
            if (start_wr)
            begin
                started <= 1'b1;
            end
            // any other byte to the refresh register breaks the sequence
            if (wr & (idx == `IDX_REFRESH))
            begin
                refresh_armed <= (wbyte == `REFRESH_ARM);
            end
        end
    end

    // down-counter; reloads on reset, refresh and underflow, held until options are known
    always @(posedge clk)
    begin
        if (reinit | ~opt_valid | refresh_fire | underflow)
        begin
            counter <= load_val;
        end
        else if (tick)
        begin
            counter <= counter - {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    end

    // underflow action: reset request pulse or sticky interrupt bit
    assign clear_underflow = wr & (idx == `IDX_IRQ_CLEAR) & wbyte[`IRQ_UNDERFLOW];

    always @(posedge clk)
    begin
        if (reinit)
        begin
            wdog_reset <= 1'b0;
        end
        else
        begin
            wdog_reset <= underflow & action_sel;
        end
    end

    // set wins over a clear in the same cycle
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            irq_status <= 1'b0;
        end
        else if (underflow & ~action_sel)
        begin
            irq_status <= 1'b1;
        end
        else if (clear_underflow)
        begin
            irq_status <= 1'b0;
        end
    end

    assign irq = irq_status & irq_enable;

    // watchdog control registers, reinitialised by every kind of reset
    always @(posedge clk)
    begin
        if (reinit)
        begin
            action_sel    <= 1'b0;
            prescale_sel  <= `RST_PRESCALE;
            protect_mode  <= `RST_PROTECT;
            periodic_ctrl <= `RST_PERIODIC;
        end
        else if (wr)
        begin
            case (idx)
                `IDX_ACTION_SEL: action_sel   <= wbyte[`ACTION_BIT];
                `IDX_CONTROL:    prescale_sel <= wbyte[`PRESCALE_HI:`PRESCALE_LO];
                `IDX_PROTECT:    protect_mode <= wbyte;
                `IDX_PERIODIC:   periodic_ctrl <= wbyte;
                default:         ;
            endcase
        end
    end

    // interrupt enable survives warm resets like the status bit
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            irq_enable <= `RST_IRQ_ENABLE;
        end
        else if (wr & (idx == `IDX_IRQ_ENABLE))
        begin
            irq_enable <= wbyte[`IRQ_UNDERFLOW];
        end
    end

    // reset-cause flags; only resetn (power-on) clears the cold flag
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            cold_flag <= 1'b0;
            pin_flag  <= 1'b0;
            prog_flag <= 1'b0;
            dog_flag  <= 1'b0;
        end
        else
        begin
            if (wr & (idx == `IDX_CAUSE) & wbyte[`FLAG_COLD])
            begin
                cold_flag <= 1'b1;
            end
            // simultaneous causes: pin over program over watchdog
            if (sys_reset)
            begin
                pin_flag  <= pinrst_s2;
                prog_flag <= ~pinrst_s2 & program_reset;
                dog_flag  <= ~pinrst_s2 & ~program_reset;
            end
        end
    end

    // single-cycle ack; unmapped indices answer zero and ignore writes
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= req;
            if (req & ~wb_we_i)
            begin
                case (idx)
                    `IDX_ACTION_SEL: wb_dat_o <= {24'h000000, action_sel, 7'h00};
                    `IDX_CONTROL:    wb_dat_o <= {24'h000000, prescale_sel, counter[COUNT_W-3:COUNT_W-8]};
                    `IDX_PROTECT:    wb_dat_o <= {24'h000000, protect_mode};
                    `IDX_PERIODIC:   wb_dat_o <= {24'h000000, periodic_ctrl};
                    `IDX_IRQ_STATUS: wb_dat_o <= {31'h00000000, irq_status};
                    `IDX_IRQ_ENABLE: wb_dat_o <= {31'h00000000, irq_enable};
                    `IDX_CAUSE:      wb_dat_o <= {28'h0000000, dog_flag, prog_flag, pin_flag, cold_flag};
                    default:         wb_dat_o <= 32'h00000000;
                endcase
            end
            else
            begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

endmodule

// file: hdl/wdog_defs.vh
/*
 * Register indices, field positions, reset values and count constants of
 * the watchdog and reset-cause block. Byte address on the bus is four
 * times the index; the includer takes these as plain text macros.
 */
`ifndef WDOG_DEFS_VH
`define WDOG_DEFS_VH

// register indices (byte address = index * 4)
`define IDX_ACTION_SEL  8'h30
`define IDX_REFRESH     8'h31
`define IDX_START       8'h32
`define IDX_CONTROL     8'h33
`define IDX_PROTECT     8'h34
`define IDX_PERIODIC    8'h35
`define IDX_IRQ_STATUS  8'h3C
`define IDX_IRQ_CLEAR   8'h3D
`define IDX_IRQ_ENABLE  8'h3E
`define IDX_CAUSE       8'h5F

// reset values
`define RST_PROTECT     8'h00
`define RST_PERIODIC    8'h00
`define RST_PRESCALE    2'b01
`define RST_IRQ_ENABLE  1'b0

// field positions
`define ACTION_BIT      7
`define PRESCALE_HI     7
`define PRESCALE_LO     6
`define FLAG_COLD       0
`define FLAG_PIN        1
`define FLAG_PROG       2
`define FLAG_DOG        3
`define IRQ_UNDERFLOW   0

// refresh sequence bytes
`define REFRESH_ARM     8'h00
`define REFRESH_FIRE    8'hFF

// prescale select codes and divider masks
`define PS_DIV2         2'b00
`define PS_DIV16        2'b01
`define PS_DIV128       2'b10
`define PS_LOCO         2'b11
`define MASK_DIV2       7'h01
`define MASK_DIV16      7'h0F
`define MASK_DIV128     7'h7F
`define LOCO_DIV_MASK   4'hF

// count values per option select code
`define COUNT_SEL0      16'h03FF
`define COUNT_SEL1      16'h0FFF
`define COUNT_SEL2      16'h1FFF
`define COUNT_SEL3      16'h3FFF

// cycles after reset release before option pins are trusted
`define OPT_SETTLE      2'd2

`endif

// file: test/wdog_checker_sva.sv
/*
 checker for the watchdog block: bus answer timing and output pulses.
 assumes it is bound to the top module and sees only its ports.
*/
`include "wdog_defs.vh"
module wdog_checker (
    input logic        clk,
    input logic        resetn,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [9:0]  wb_adr_i,
    input logic [31:0] wb_dat_o,
    input logic        wb_ack_o,
    input logic        wdog_reset,
    input logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // bus answer exactly one cycle after the request is taken
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    property p_dat_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_upper: assert property (p_dat_upper) else $error("upper lanes set");
    // unassigned flag bits never read as one
    property p_cause_upper;
        wb_ack_o && $past(wb_adr_i[9:2]) == `IDX_CAUSE |-> wb_dat_o[7:4] == 4'h0;
    endproperty
    a_cause_upper: assert property (p_cause_upper) else $error("cause upper bits");
    property p_wo_read;
        wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:2]) == `IDX_REFRESH |-> wb_dat_o == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("refresh readable");
    property p_dog_pulse; wdog_reset |=> !wdog_reset; endproperty
    a_dog_pulse: assert property (p_dog_pulse) else $error("reset pulse long");
    // the reset route must not also raise the interrupt
    property p_dog_no_irq; wdog_reset |-> !$rose(irq); endproperty
    a_dog_no_irq: assert property (p_dog_no_irq) else $error("irq with reset");
    property p_rst_quiet; $rose(resetn) |-> !irq && !wdog_reset && !wb_ack_o; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs after reset");
    // shortest period is far above eight cycles
    property p_early; $rose(resetn) |-> !wdog_reset [*8]; endproperty
    a_early: assert property (p_early) else $error("underflow too soon");

    c_dog: cover property (wdog_reset);
    c_irq: cover property ($rose(irq));
    c_wr: cover property (wb_ack_o && $past(wb_we_i));
endmodule

bind wdog_reset_flags wdog_checker u_chk (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wdog_reset(wdog_reset), .irq(irq));

// file: test/wdog_reset_flags_tb.sv
/*
 self-checking bench for the watchdog and reset-cause block.
 assumes short count parameters 4..7; option select 11b (count 7) unless a scenario picks another code.
*/
`include "wdog_defs.vh"
module wdog_reset_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, auto = 0;
    logic        loco = 0, pin = 0, prog = 0, cwait = 0, cstop = 0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = 32'h0;
    logic [2:0]  lc = 3'h0;
    logic [1:0]  cvs = 2'b11;
    logic [7:0]  rd;
    wire  [31:0] rdat;
    wire         ack, wrst, irq;
    int          err_count = 0, checks_done = 0, cc = 0, n, t0, r;

    always #20 clk = ~clk;
    // cycle count and a slow oscillator of eight clocks per period
    always @(posedge clk)
    begin
        cc <= cc + 1;
        lc <= lc + 3'h1;
        loco <= lc[2];
    end

    wdog_reset_flags #(.COUNT_VAL0(4), .COUNT_VAL1(5), .COUNT_VAL2(6), .COUNT_VAL3(7)) u_dut (
        .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .auto_start_option(auto), .count_value_select(cvs), .loco_clk_pin(loco),
        .pin_reset(pin), .program_reset(prog), .cpu_wait(cwait), .cpu_stop(cstop),
        .wdog_reset(wrst), .irq(irq));

    task end_sim;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // division ratio of a cpu-clock prescale code
    function automatic int div_of(input int code);
        return (code == 0) ? 2 : (code == 1) ? 16 : 128;
    endfunction

    // one classic cycle; held until ack is sampled high
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
        k = 0;
        do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 16);
        if (ack !== 1'b1)
        begin
            err_count++;
            end_sim;
        end
        rd = rdat[7:0];
        cyc <= 0; stb <= 0; we <= 0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task rdchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk({24'h0, rd}, {24'h0, exp});
    endtask

    task refresh;
        wr(`IDX_REFRESH, `REFRESH_ARM);
        wr(`IDX_REFRESH, `REFRESH_FIRE);
    endtask

    // bounded wait for the interrupt line
    task waitirq(input int lim);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin @(posedge clk); n++; end
        if (irq !== 1'b1)
        begin
            err_count++;
            end_sim;
        end
    endtask

    // options are trusted only three edges after release
    task do_reset(input logic a);
        auto <= a; resetn <= 0;
        repeat (6) @(posedge clk);
        resetn <= 1;
        repeat (4) @(posedge clk);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        end_sim;
    end

    initial
    begin
        void'($urandom(32'h4da4));
        do_reset(1'b0);
        rdchk(`IDX_CONTROL, 8'h40);
        rdchk(`IDX_ACTION_SEL, 8'h00);
        rdchk(`IDX_PERIODIC, 8'h00);
        rdchk(`IDX_PROTECT, 8'h00);
        rdchk(`IDX_CAUSE, 8'h00);
        rdchk(`IDX_REFRESH, 8'h00);
        rdchk(8'h40, 8'h00);
        repeat (6) begin r = $urandom_range(0, 255); wr(`IDX_PERIODIC, r[7:0]); rdchk(`IDX_PERIODIC, r[7:0]); end
        sel <= 4'hE;
        wr(`IDX_PERIODIC, 8'h00);
        sel <= 4'hF;
        rdchk(`IDX_PERIODIC, r[7:0]);
        wr(`IDX_IRQ_ENABLE, 8'h01);
        // period per prescale code; refresh leaves the prescaler phase alone
        for (int c = 0; c < 3; c++)
        begin
            r = div_of(c);
            wr(`IDX_CONTROL, {c[1:0], 6'h00});
            refresh;
            t0 = cc;
            wr(`IDX_IRQ_CLEAR, 8'h01);
            waitirq(1200);
            chk(cc - t0 >= r * 6 - 2 && cc - t0 <= r * 7 + 3, 1);
        end
        wr(`IDX_IRQ_ENABLE, 8'h00);
        chk(irq, 0);
        rdchk(`IDX_IRQ_STATUS, 8'h01);
        wr(`IDX_IRQ_CLEAR, 8'h01);
        wr(`IDX_IRQ_ENABLE, 8'h01);
        // frequent refreshes hold underflow off
        wr(`IDX_CONTROL, 8'h40);
        refresh;
        wr(`IDX_IRQ_CLEAR, 8'h01);
        repeat (15) begin repeat ($urandom_range(2, 8)) @(posedge clk); refresh; end
        rdchk(`IDX_IRQ_STATUS, 8'h00);
        // wait or stop freezes a cpu-clock count
        r = $urandom_range(1, 3);
        {cwait, cstop} <= r[1:0];
        wr(`IDX_CONTROL, 8'h00);
        refresh;
        wr(`IDX_IRQ_CLEAR, 8'h01);
        repeat (60) @(posedge clk);
        rdchk(`IDX_IRQ_STATUS, 8'h00);
        {cwait, cstop} <= 2'b00;
        waitirq(40);
        // the oscillator source keeps counting in stop
        cstop <= 1;
        wr(`IDX_CONTROL, 8'hC0);
        refresh;
        t0 = cc;
        wr(`IDX_IRQ_CLEAR, 8'h01);
        waitirq(1500);
        chk(cc - t0 >= 600, 1);
        cstop <= 0;
        wr(`IDX_CAUSE, 8'h01);
        wr(`IDX_CAUSE, 8'h00);
        rdchk(`IDX_CAUSE, 8'h01);
        wr(`IDX_CONTROL, 8'h00);
        wr(`IDX_ACTION_SEL, 8'h80);
        rdchk(`IDX_ACTION_SEL, 8'h80);
        n = 0;
        while (wrst !== 1'b1 && n < 100) begin @(posedge clk); n++; end
        chk(wrst, 1);
        if (wrst !== 1'b1)
            end_sim;
        repeat (3) @(posedge clk);
        rdchk(`IDX_CAUSE, 8'h09);
        pin <= 1;
        repeat (3) @(posedge clk);
        pin <= 0;
        repeat (4) @(posedge clk);
        rdchk(`IDX_CAUSE, 8'h03);
        prog <= 1;
        @(posedge clk);
        prog <= 0;
        repeat (2) @(posedge clk);
        rdchk(`IDX_CAUSE, 8'h05);
        wr(`IDX_CAUSE, 8'h0E);
        rdchk(`IDX_CAUSE, 8'h05);
        do_reset(1'b0);
        rdchk(`IDX_CAUSE, 8'h00);
        // stopped after reset until start is written
        do_reset(1'b1);
        wr(`IDX_IRQ_ENABLE, 8'h01);
        repeat (150) @(posedge clk);
        chk(irq, 0);
        wr(`IDX_START, 8'h5A);
        waitirq(200);
        chk(irq, 1);
        // another count select code gives its own reload count (bench counts 4, 5, 6)
        r = $urandom_range(0, 2);
        cvs <= r[1:0];
        do_reset(1'b0);
        wr(`IDX_IRQ_ENABLE, 8'h01);
        refresh;
        t0 = cc;
        wr(`IDX_IRQ_CLEAR, 8'h01);
        waitirq(300);
        chk(cc - t0 >= 16 * (r + 3) - 2 && cc - t0 <= 16 * (r + 4) + 3, 1);
        end_sim;
    end
endmodule
